// [pkg/card_alert_pkg.sv]
// constants, types and state enum for the card presence and fault alert block
// assumes a single 200 MHz clock and a synchronous active-high reset
//
// Functional notes
// R1 - a high-to-low edge on session_request_n starts a card session
// R2 - host keeps session_request_n high while no session is running
// R3 - outside a session alert low when no card; either switch polarity
// R4 - outside a session alert high while a debounced card is present
// R5 - with a card in, alert drops low at once on supply lockout
// R6 - alert returns high when lockout clears and card still present
// R7 - during a session any fault drives alert low
// R8 - a fault in session starts deactivation at once without host
// R9 - after a fault host raises request, samples alert after deactivation
// R10 - insertion debounce timer of eight milliseconds
// R11 - after insertion alert stays low until debounce has expired
// R12 - card removal deactivates at once and drops alert, no debounce
// R13 - deactivation: reset low, clock low 12 us later, data/aux low, supply off
// R14 - request returning high ends session with the same deactivation
// R15 - presence drop during debounce abandons it; restart on next insertion
// R16 - request ignored without debounced card or while fault alert low
package card_alert_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLOCK_MHZ          = 200;
	localparam int DEBOUNCE_MS        = 8;
	localparam int DEBOUNCE_CYCLES    = DEBOUNCE_MS * 1000 * CLOCK_MHZ;
	localparam int CLOCK_STOP_US      = 12;
	localparam int CLOCK_STOP_CYCLES  = CLOCK_STOP_US * CLOCK_MHZ;
	localparam int TIMER_W            = 24;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		st_idle,
		st_active,
		st_deact_reset,
		st_deact_lines,
		st_deact_supply
	} session_state_t;

	// card side drive levels; the supervisor sets all four on when
	// a session opens and clears them in order on deactivation
	typedef struct packed {
		logic reset_level;
		logic clock_enable;
		logic data_enable;
		logic supply_enable;
	} card_drive_t;

	localparam card_drive_t DRIVE_OFF = '{1'b0, 1'b0, 1'b0, 1'b0};
	localparam card_drive_t DRIVE_ON  = '{1'b1, 1'b1, 1'b1, 1'b1};

	// fault sources seen during a session
	typedef struct packed {
		logic overload;
		logic overheat;
		logic supply_fault;
	} fault_in_t;

endpackage

// [hdl/sync_two_flop.sv]
// two flip-flop synchroniser for asynchronous level inputs
// assumes one clock domain and synchronous reset
`timescale 1ns/1ps
module sync_two_flop #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// first stage is read only by the second
	always_ff @(posedge clock) begin
		if (reset) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule // sync_two_flop

// [hdl/card_presence_fault_alert.sv]
// card session supervisor: presence debounce, fault alert, deactivation
// assumes pins are asynchronous and pass a two-flop synchroniser here
`timescale 1ns/1ps
module card_presence_fault_alert
	import card_alert_pkg::*;
#(
	parameter int DEBOUNCE_COUNT   = DEBOUNCE_CYCLES,
	parameter int CLOCK_STOP_COUNT = CLOCK_STOP_CYCLES
) (
	input  wire logic      clock,
	input  wire logic      reset,
	input  wire logic      session_request_n,
	input  wire logic      card_presence_in,
	input  wire logic      presence_active_high,
	input  wire logic      supply_low_lockout,
	input  wire fault_in_t fault_in,
	output logic           alert_n,
	output logic           session_active,
	output logic           card_reset_out,
	output logic           card_clock_enable,
	output logic           card_data_enable,
	output logic           card_supply_out
);

	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	if (DEBOUNCE_COUNT < 1 || DEBOUNCE_COUNT >= (1 << TIMER_W))
		$error("DEBOUNCE_COUNT out of range");
	if (CLOCK_STOP_COUNT < 1 || CLOCK_STOP_COUNT >= (1 << TIMER_W))
		$error("CLOCK_STOP_COUNT out of range");

	localparam logic [TIMER_W-1:0] DEB_LAST  = TIMER_W'(DEBOUNCE_COUNT - 1);
	localparam logic [TIMER_W-1:0] STOP_LAST = TIMER_W'(CLOCK_STOP_COUNT - 1);

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	logic [5:0] pins_s;
	sync_two_flop #(.WIDTH(6)) u_sync (
		.clock    (clock),
		.reset    (reset),
		// request enters inverted so the cleared synchroniser reads as idle high
		.async_in ({~session_request_n, card_presence_in, supply_low_lockout,
		            fault_in.overload, fault_in.overheat, fault_in.supply_fault}),
		.sync_out (pins_s)
	);

	logic req_n_s;
	logic pres_raw_s;
	logic lockout_s;
	logic fault_s;
	logic card_in;
	assign req_n_s    = ~pins_s[5]; // no false falling edge right after reset
	assign pres_raw_s = pins_s[4];
	assign lockout_s  = pins_s[3];
	assign fault_s    = |pins_s[2:0];
	// either switch type: strap picks the active level
	assign card_in    = presence_active_high ? pres_raw_s : ~pres_raw_s; // R3

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		session_state_t    state;
		logic              req_n_prev;
		logic              card_ok;     // debounced presence
		logic              fault_latch; // holds alert low after a fault
		logic [TIMER_W-1:0] deb_cnt;
		logic [TIMER_W-1:0] stop_cnt;
		card_drive_t       drive;
		logic              alert_n;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		s_nxt            = s_r;
		s_nxt.req_n_prev = req_n_s;

		// debounce: removal is instant, insertion waits the full interval
		if (!card_in) begin
			s_nxt.card_ok = 1'b0; // R12
			s_nxt.deb_cnt = '0;   // R15
		end else if (!s_r.card_ok) begin
			if (s_r.deb_cnt == DEB_LAST) begin
				s_nxt.card_ok = 1'b1; // R10 R11
			end else begin
				s_nxt.deb_cnt = s_r.deb_cnt + 1'b1;
			end
		end

		unique case (s_r.state)
			st_idle: begin
				s_nxt.drive = DRIVE_OFF;
				// fault latch is dropped once the host has released the request
				if (req_n_s) begin
					s_nxt.fault_latch = 1'b0; // R9
				end
				if (s_r.req_n_prev && !req_n_s && s_r.card_ok && !lockout_s
				    && !s_r.fault_latch && card_in) begin
					s_nxt.state = st_active; // R1 R16
					s_nxt.drive = DRIVE_ON;
				end
			end
			st_active: begin
				// any abort path enters the same deactivation
				if (fault_s || lockout_s || !card_in) begin
					s_nxt.fault_latch = 1'b1; // R7 R8 R12
				end
				if (fault_s || lockout_s || !card_in || req_n_s) begin
					s_nxt.state             = st_deact_reset; // R8 R14
					s_nxt.drive.reset_level = 1'b0;           // R13
					s_nxt.stop_cnt          = '0;
				end
			end
			st_deact_reset: begin
				if (fault_s || lockout_s || !card_in) begin
					s_nxt.fault_latch = 1'b1;
				end
				if (s_r.stop_cnt == STOP_LAST) begin
					s_nxt.state              = st_deact_lines;
					s_nxt.drive.clock_enable = 1'b0; // R13
				end else begin
					s_nxt.stop_cnt = s_r.stop_cnt + 1'b1;
				end
			end
			st_deact_lines: begin
				s_nxt.state             = st_deact_supply;
				s_nxt.drive.data_enable = 1'b0; // R13
			end
			st_deact_supply: begin
				s_nxt.state               = st_idle;
				s_nxt.drive.supply_enable = 1'b0; // R13
			end
			default: begin
				s_nxt.state = st_idle;
				s_nxt.drive = DRIVE_OFF;
			end
		endcase

		// alert: low with no debounced card, on lockout, or after a fault
		s_nxt.alert_n = s_nxt.card_ok && card_in && !lockout_s
		                && !s_nxt.fault_latch; // R3 R4 R5 R6 R7
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			s_r            <= '0;
			s_r.state      <= st_idle;
			s_r.req_n_prev <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign alert_n           = s_r.alert_n;
	assign session_active    = (s_r.state == st_active);
	assign card_reset_out    = s_r.drive.reset_level;
	assign card_clock_enable = s_r.drive.clock_enable;
	assign card_data_enable  = s_r.drive.data_enable;
	assign card_supply_out   = s_r.drive.supply_enable;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_no_card_low: assert property (@(posedge clock) disable iff (reset) // R3
		!card_in |=> !alert_n)
		else $error("alert high with no card");

	a_lockout_low: assert property (@(posedge clock) disable iff (reset) // R5
		lockout_s |=> !alert_n)
		else $error("alert high during lockout");

	a_lockout_recover: assert property (@(posedge clock) disable iff (reset) // R6
		$fell(lockout_s) && card_in && s_r.card_ok && !s_r.fault_latch
		&& !fault_s && $stable(card_in) |=> alert_n)
		else $error("alert not restored after lockout");

	a_fault_deact: assert property (@(posedge clock) disable iff (reset) // R8
		session_active && fault_s |=> s_r.state == st_deact_reset && !card_reset_out
		&& !alert_n)
		else $error("fault did not start deactivation");

	a_debounce_hold: assert property (@(posedge clock) disable iff (reset) // R11
		$rose(card_in) |=> !alert_n [*8])
		else $error("alert rose before debounce");

	a_clock_stop: assert property (@(posedge clock) disable iff (reset) // R13
		$fell(card_reset_out) |-> card_clock_enable ##1 card_clock_enable)
		else $error("clock stopped with reset");

	a_deact_order: assert property (@(posedge clock) disable iff (reset) // R13
		$fell(card_clock_enable) |=> !card_data_enable ##1 !card_supply_out)
		else $error("deactivation order wrong");

	a_release_end: assert property (@(posedge clock) disable iff (reset) // R14
		session_active && req_n_s |=> s_r.state == st_deact_reset)
		else $error("release did not deactivate");

	a_ignore_req: assert property (@(posedge clock) disable iff (reset) // R16
		s_r.state == st_idle && !s_r.card_ok |=> !session_active)
		else $error("session opened without card");

	a_removal_fast: assert property (@(posedge clock) disable iff (reset) // R12
		session_active && !card_in |=> !session_active && !alert_n)
		else $error("removal not handled at once");

endmodule // card_presence_fault_alert

// [sim/host_model.sv]
// host side model: drives the session request, samples the alert
// assumes the bench commands it through want_session at falling edges
`timescale 1ns/1ps
module host_model (
	input  wire logic clock,
	input  wire logic want_session,
	input  wire logic alert_n,
	input  wire logic card_supply_out,
	output logic      session_request_n,
	output logic      alert_seen
);
	logic want_r = 1'b0;

	initial session_request_n = 1'b1;

	// bench command taken on the rising edge, so no race with the bench
	always @(posedge clock)
		want_r <= want_session;

	// request idles high; a falling level opens a session
	always @(negedge clock) begin
		session_request_n <= !want_r;
		// alert only trusted once the card supply is off again
		if (session_request_n && !card_supply_out)
			alert_seen <= alert_n;
	end
endmodule // host_model

// [sim/test_card_presence_fault_alert.sv]
// self-checking bench for the card presence and fault alert block
// assumes short debounce and clock stop counts, set here as parameters
`timescale 1ns/1ps
module test_card_presence_fault_alert;
	import card_alert_pkg::*;
	localparam int DEB  = 20;
	localparam int STOP = 5;
	typedef struct {logic [5:0] v; int gap;} note_t;
	logic       clock = 0, reset = 1, want = 0, here = 0, pol = 0, lockout = 0;
	fault_in_t  fault_in = '0;
	logic       alert_n, active, rst_o, clk_o, dat_o, sup_o, req_n, seen;
	logic [5:0] prev = '0;
	int         failures = 0, n_tests = 0, cyc = 0, last = 0, seed = 43;
	note_t      q[$];
	wire  [5:0] vec = {alert_n, active, rst_o, clk_o, dat_o, sup_o};

	always #2.5 clock = !clock;

	host_model host (.clock(clock), .want_session(want), .alert_n(alert_n),
		.card_supply_out(sup_o), .session_request_n(req_n), .alert_seen(seen));

	card_presence_fault_alert #(.DEBOUNCE_COUNT(DEB), .CLOCK_STOP_COUNT(STOP)) dut (
		.clock(clock), .reset(reset), .session_request_n(req_n),
		.card_presence_in(here == pol), .presence_active_high(pol),
		.supply_low_lockout(lockout), .fault_in(fault_in), .alert_n(alert_n),
		.session_active(active), .card_reset_out(rst_o), .card_clock_enable(clk_o),
		.card_data_enable(dat_o), .card_supply_out(sup_o));

	task automatic check(input logic [5:0] seen, exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic note(input logic [5:0] v, input int gap = -1);
		q.push_back('{v, gap});
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clock);
	endtask

	// bounded wait for every noted output change to show up
	task automatic settle();
		for (int i = 0; i < 60 && q.size() != 0; i++)
			@(negedge clock);
		if (q.size() != 0) begin
			check(6'(q.size()), 6'h00, "pending changes");
			complete_run();
		end
	endtask

	// every output change must match the oldest note, in order, and in spacing where the note gives a gap;
	// sampled on the falling edge, where registered outputs have settled
	always @(negedge clock) begin
		cyc <= cyc + 1;
		if (!reset && vec !== prev) begin
			prev <= vec;
			last <= cyc;
			if (q.size() == 0)
				check(vec, prev, "unexpected change");
			else begin
				check(vec, q[0].v, "outputs");
				if (q[0].gap >= 0)
					check(6'(cyc - last), 6'(q[0].gap), "step gap");
				void'(q.pop_front());
			end
		end
	end

	initial begin
		int k;
		idle(6);
		reset = 0;
		idle(4);
		for (int p = 0; p < 2; p++) begin
			pol = p[0];
			idle(4);
			// request with no debounced card, during a bounce shorter than debounce
			want = 1;
			here = 1;
			idle(10);
			here = 0;
			want = 0;
			idle(DEB + 10);
			check({5'h00, alert_n}, 6'h00, "bounce alert");
			note(6'h20);
			here = 1;
			idle(DEB);
			check({5'h00, alert_n}, 6'h00, "debounce alert");
			settle();
			// lockout outside a session; request during it is refused
			note(6'h00);
			note(6'h20);
			lockout = 1;
			idle(4);
			check({5'h00, alert_n}, 6'h00, "lockout alert");
			want = 1;
			idle(8);
			lockout = 0;
			settle();
			want = 0;
			idle(4);
			// normal end, fault or lockout, then card removal
			for (int s = 0; s < 3; s++) begin
				note(6'h3F);
				want = 1;
				idle(8);
				if (s == 0) begin
					note(6'h27);
					note(6'h23, STOP);
					note(6'h21, 1);
					note(6'h20, 1);
					want = 0;
				end else begin
					note(6'h07);
					note(6'h03, STOP);
					note(6'h01, 1);
					note(6'h00, 1);
					k = $unsigned($random(seed)) % 4;
					if (s == 2)
						here = 0;
					else if (k == 3)
						lockout = 1;
					else
						fault_in[k] = 1'b1;
					idle(4);
					check({5'h00, alert_n}, 6'h00, "fault alert");
					settle();
					lockout = 0;
					fault_in = '0;
					if (s == 1)
						note(6'h20);
					want = 0;
				end
				settle();
				idle(4);
				check({5'h00, seen}, {5'h00, here}, "alert after release");
			end
		end
		complete_run();
	end
endmodule // test_card_presence_fault_alert
